// ---- hw/mmr_block_ram.sv ----
// The register addresses and register access over Wishbone are this design's own decisions.
module mmr_block_ram
   import mmr_pkg::*;
#(
   parameter mmr_mode_t MODE = MMR_TDP,
   parameter int A_WIDTH = 16,
   parameter int B_WIDTH = 16,
   parameter bit OUT_REG = 1'b0,
   parameter mmr_same_t RDW_SAME = MMR_SAME_NEW,
   parameter mmr_mixed_t RDW_MIXED = MMR_MIX_OLD,
   parameter int SR_WIDTH = 4,
   parameter int SR_LEN = 16,
   parameter int SR_TAPS = 4,
   parameter logic [MMR_CAP_BITS-1:0] INIT_IMAGE = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic a_ce_i,
   input wire logic [MMR_AW-1:0] a_addr_i,
   input wire logic [MMR_DW-1:0] a_data_i,
   input wire logic a_wren_i,
   input wire logic a_rden_i,
   output logic [MMR_DW-1:0] a_q_o,
   input wire logic b_ce_i,
   input wire logic [MMR_AW-1:0] b_addr_i,
   input wire logic [MMR_DW-1:0] b_data_i,
   input wire logic b_wren_i,
   input wire logic b_rden_i,
   output logic [MMR_DW-1:0] b_q_o,
   output logic [MMR_TAP_W-1:0] taps_o,
   output logic fifo_empty_o,
   output logic fifo_full_o
);

   // True when a width is a legal shape; wide shapes only in simple dual
   function automatic bit shape_ok(input int w, input bit wide);
      return w == 1 || w == 2 || w == 4 || w == 8 || w == 16 || w == 9 ||
         w == 18 || (wide && (w == 32 || w == 36));
   endfunction

   // Two bit ranges of the flat store overlap
   function automatic bit overlaps(input int ba, input int wa, input int bb,
                                   input int wb);
      return (ba < bb + wb) && (bb < ba + wa);
   endfunction

   // Parity shapes use the full 9216 bits, plain shapes 8192
   localparam bit PARITY = (A_WIDTH % MMR_PARITY_UNIT) == 0;
   localparam int CAP = PARITY ? MMR_CAP_BITS : MMR_PLAIN_BITS;
   localparam bit IS_SDP = MODE == MMR_SDP;
   localparam bit IS_TDP = MODE == MMR_TDP;
   localparam int FIFO_DEPTH = CAP / A_WIDTH;
   localparam int SR_SLOTS = SR_LEN * SR_TAPS;
   localparam bit CFG_OK = shape_ok(A_WIDTH, IS_SDP) &&
      shape_ok(B_WIDTH, IS_SDP) && (!IS_TDP || (A_WIDTH <= MMR_TDP_MAX_W &&
      B_WIDTH <= MMR_TDP_MAX_W)) && (((A_WIDTH % MMR_PARITY_UNIT) == 0) ==
      ((B_WIDTH % MMR_PARITY_UNIT) == 0));

   logic [MMR_CAP_BITS-1:0] mem = INIT_IMAGE;
   logic [1:0] ctrl;
   logic conflict;
   logic [MMR_AW-1:0] wptr;
   logic [MMR_AW-1:0] rptr;
   logic [MMR_AW:0] level;
   logic [MMR_AW-1:0] sr_ptr;
   logic [A_WIDTH-1:0] a_s1;
   logic [B_WIDTH-1:0] b_s1;
   logic [MMR_TAP_W-1:0] taps_s1;
   logic a_en, b_en, a_wr, b_wr, a_rd, b_rd, clash;
   logic push, pop, sr_step;
   int a_base, b_base;

   // Port activity; each port's enable is its clock enable gated by its control bit
   always_comb begin
      a_en = a_ce_i & ctrl[MMR_CTRL_CE_A];
      b_en = b_ce_i & ctrl[MMR_CTRL_CE_B];
      a_base = int'(a_addr_i) * A_WIDTH;
      b_base = int'(b_addr_i) * B_WIDTH;
      // Writes outside the store are dropped rather than wrapped
      a_wr = (IS_SDP || IS_TDP) && a_en && a_wren_i &&
         a_base + A_WIDTH <= CAP;
      b_wr = IS_TDP && b_en && b_wren_i && b_base + B_WIDTH <= CAP;
      a_rd = (IS_TDP || MODE == MMR_ROM) && a_en && a_rden_i &&
         a_base + A_WIDTH <= CAP;
      b_rd = (IS_SDP || IS_TDP) && b_en && b_rden_i &&
         b_base + B_WIDTH <= CAP;
      clash = a_wr && b_wr && overlaps(a_base, A_WIDTH, b_base, B_WIDTH);
      push = MODE == MMR_FIFO && a_en && a_wren_i &&
         int'(level) < FIFO_DEPTH;
      // A pop on an empty queue is ignored, which also covers the
      // unsupported read-with-write on empty
      pop = MODE == MMR_FIFO && b_en && b_rden_i && level != '0;
      sr_step = MODE == MMR_SHIFT && a_en && a_wren_i;
   end

   // Storage writes; no arbitration, so a double write poisons the word
   always_ff @(posedge clk_i) begin
      if (a_wr) begin
         mem[a_base +: A_WIDTH] <= a_data_i[A_WIDTH-1:0];
      end
      if (b_wr) begin
         mem[b_base +: B_WIDTH] <= b_data_i[B_WIDTH-1:0];
      end
      if (clash) begin
         mem[a_base +: A_WIDTH] <= {A_WIDTH{1'bx}};
         mem[b_base +: B_WIDTH] <= {B_WIDTH{1'bx}};
      end
      if (push) begin
         mem[int'(wptr) * A_WIDTH +: A_WIDTH] <= a_data_i[A_WIDTH-1:0];
      end
      if (sr_step) begin
         mem[int'(sr_ptr) * SR_WIDTH +: SR_WIDTH] <= a_data_i[SR_WIDTH-1:0];
      end
   end

   // Port A read stage; old data comes from mem before this edge's write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a_s1 <= '0;
      end else if (a_rd) begin
         if (a_wr && RDW_SAME == MMR_SAME_NEW) begin
            a_s1 <= a_data_i[A_WIDTH-1:0];
         end else if (b_wr && RDW_MIXED == MMR_MIX_DC &&
                      overlaps(a_base, A_WIDTH, b_base, B_WIDTH)) begin
            a_s1 <= {A_WIDTH{1'bx}};
         end else begin
            a_s1 <= mem[a_base +: A_WIDTH];
         end
      end
   end

   // Port B read stage, also the FIFO read side
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         b_s1 <= '0;
      end else if (pop) begin
         b_s1 <= mem[int'(rptr) * A_WIDTH +: B_WIDTH];
      end else if (b_rd) begin
         if (b_wr && RDW_SAME == MMR_SAME_NEW) begin
            b_s1 <= b_data_i[B_WIDTH-1:0];
         end else if (a_wr && RDW_MIXED == MMR_MIX_DC &&
                      overlaps(a_base, A_WIDTH, b_base, B_WIDTH)) begin
            b_s1 <= {B_WIDTH{1'bx}};
         end else begin
            b_s1 <= mem[b_base +: B_WIDTH];
         end
      end
   end

   // Shift taps: slot ptr-(k+1)*len holds the word delayed by (k+1)*len
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         taps_s1 <= '0;
         sr_ptr <= '0;
      end else if (sr_step) begin
         for (int k = 0; k < SR_TAPS; k++) begin
            taps_s1[k*SR_WIDTH +: SR_WIDTH] <= mem[((int'(sr_ptr) +
               SR_SLOTS - (k + 1) * SR_LEN) % SR_SLOTS) * SR_WIDTH +:
               SR_WIDTH];
         end
         sr_ptr <= (int'(sr_ptr) == SR_SLOTS - 1) ? '0 :
            MMR_AW'(int'(sr_ptr) + 1);
      end
   end

   // Output stage: with OUT_REG the stage-one word moves out one edge late
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         a_q_o <= '0;
         b_q_o <= '0;
         taps_o <= '0;
      end else begin
         if (OUT_REG) begin
            if (a_en) begin
               a_q_o <= MMR_DW'(a_s1);
            end
            if (b_en) begin
               b_q_o <= MMR_DW'(b_s1);
            end
            if (a_en) begin
               taps_o <= taps_s1;
            end
         end else begin
            if (a_rd) begin
               a_q_o <= MMR_DW'(a_wr && RDW_SAME == MMR_SAME_NEW ?
                  a_data_i[A_WIDTH-1:0] : (b_wr && RDW_MIXED == MMR_MIX_DC &&
                  overlaps(a_base, A_WIDTH, b_base, B_WIDTH)) ?
                  {A_WIDTH{1'bx}} : mem[a_base +: A_WIDTH]);
            end
            if (pop || b_rd) begin
               b_q_o <= MMR_DW'(pop ? mem[int'(rptr) * A_WIDTH +: B_WIDTH] :
                  b_wr && RDW_SAME == MMR_SAME_NEW ? b_data_i[B_WIDTH-1:0] :
                  (a_wr && RDW_MIXED == MMR_MIX_DC && overlaps(a_base,
                  A_WIDTH, b_base, B_WIDTH)) ? {B_WIDTH{1'bx}} :
                  mem[b_base +: B_WIDTH]);
            end
            if (sr_step) begin
               for (int k = 0; k < SR_TAPS; k++) begin
                  taps_o[k*SR_WIDTH +: SR_WIDTH] <= mem[((int'(sr_ptr) +
                     SR_SLOTS - (k + 1) * SR_LEN) % SR_SLOTS) * SR_WIDTH +:
                     SR_WIDTH];
               end
            end
         end
      end
   end

   // FIFO pointers and level; flags are registered for the output pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wptr <= '0;
         rptr <= '0;
         level <= '0;
         fifo_empty_o <= 1'b1;
         fifo_full_o <= 1'b0;
      end else begin
         if (push) begin
            wptr <= (int'(wptr) == FIFO_DEPTH - 1) ? '0 :
               MMR_AW'(int'(wptr) + 1);
         end
         if (pop) begin
            rptr <= (int'(rptr) == FIFO_DEPTH - 1) ? '0 :
               MMR_AW'(int'(rptr) + 1);
         end
         level <= level + (MMR_AW+1)'(push) - (MMR_AW+1)'(pop);
         fifo_empty_o <= (level + (MMR_AW+1)'(push) -
            (MMR_AW+1)'(pop)) == '0;
         fifo_full_o <= int'(level + (MMR_AW+1)'(push) -
            (MMR_AW+1)'(pop)) == FIFO_DEPTH;
      end
   end

   // Sticky record of double writes; a new clash beats a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conflict <= 1'b0;
      end else if (clash) begin
         conflict <= 1'b1;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
                   wb_adr_i == MMR_REG_STATUS && wb_sel_i[0] &&
                   wb_dat_i[MMR_ST_CONFLICT]) begin
         conflict <= 1'b0;
      end
   end

   // Wishbone slave: answer one edge after the strobe, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         ctrl <= MMR_CTRL_RESET;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= '0;
         // Writes land at the ack edge, where the master still holds them
         if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
             wb_adr_i == MMR_REG_CTRL && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[1:0];
         end
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            unique case (wb_adr_i)
               MMR_REG_CTRL: wb_dat_o <= 32'(ctrl);
               MMR_REG_STATUS: begin
                  wb_dat_o[MMR_ST_CONFLICT] <= conflict;
                  wb_dat_o[MMR_ST_EMPTY] <= fifo_empty_o;
                  wb_dat_o[MMR_ST_FULL] <= fifo_full_o;
                  wb_dat_o[MMR_ST_LEVEL_LSB +: MMR_AW+1] <= level;
               end
               // Build-time shape is readable, never writable
               MMR_REG_CONFIG: begin
                  wb_dat_o[7:0] <= 8'(MODE);
                  wb_dat_o[MMR_CFG_WA_LSB +: 8] <= 8'(A_WIDTH);
                  wb_dat_o[MMR_CFG_WB_LSB +: 8] <= 8'(B_WIDTH);
                  wb_dat_o[MMR_CFG_OREG] <= OUT_REG;
               end
               default: wb_dat_o <= '0;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence a_new_wr_s;
      a_rd && a_wr && RDW_SAME == MMR_SAME_NEW;
   endsequence

   sequence b_idle_s;
      !b_rd && !pop;
   endsequence

   cfg_legal_a: assert property (CFG_OK)
      else $error("illegal port width combination");
   new_data_a: assert property (a_new_wr_s |=> a_s1 ==
      $past(a_data_i[A_WIDTH-1:0]))
      else $error("same-port new data not shown");
   out_delay_a: assert property (OUT_REG && a_en |=>
      a_q_o == MMR_DW'($past(a_s1)))
      else $error("output register delay wrong");
   rden_hold_a: assert property (b_idle_s ##1 b_idle_s |->
      $stable(b_s1))
      else $error("read data moved without read enable");
   clash_flag_a: assert property (clash |=> conflict)
      else $error("double write not recorded");
   write_store_a: assert property (a_wr && !clash |=>
      mem[$past(a_base) +: A_WIDTH] == $past(a_data_i[A_WIDTH-1:0]))
      else $error("port A write not stored");
   old_mixed_a: assert property (b_rd && !b_wr && a_wr &&
      RDW_MIXED == MMR_MIX_OLD |=> b_s1 == $past(mem[b_base +: B_WIDTH]))
      else $error("mixed-port old data lost");
   rom_fixed_a: assert property (MODE == MMR_ROM |=>
      $stable(mem))
      else $error("ROM contents changed");
   fifo_flags_a: assert property (push && !pop ##1 !pop |->
      !fifo_empty_o)
      else $error("FIFO empty after push");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

endmodule

// ---- shared/mmr_pkg.sv ----
package mmr_pkg;
   // Storage and port geometry
   localparam int MMR_CAP_BITS = 9216;
   localparam int MMR_PLAIN_BITS = 8192;
   localparam int MMR_AW = 13;
   localparam int MMR_DW = 36;
   localparam int MMR_TDP_MAX_W = 18;
   localparam int MMR_TAP_W = 36;
   localparam int MMR_PARITY_UNIT = 9;
   // Register map (byte addresses)
   localparam logic [7:0] MMR_REG_CTRL = 8'h00;
   localparam logic [7:0] MMR_REG_STATUS = 8'h04;
   localparam logic [7:0] MMR_REG_CONFIG = 8'h08;
   // Field positions
   localparam int MMR_CTRL_CE_A = 0;
   localparam int MMR_CTRL_CE_B = 1;
   localparam int MMR_ST_CONFLICT = 0;
   localparam int MMR_ST_EMPTY = 1;
   localparam int MMR_ST_FULL = 2;
   localparam int MMR_ST_LEVEL_LSB = 16;
   localparam int MMR_CFG_WA_LSB = 8;
   localparam int MMR_CFG_WB_LSB = 16;
   localparam int MMR_CFG_OREG = 24;
   // Values after reset
   localparam logic [1:0] MMR_CTRL_RESET = 2'h3;
   // Build-time choices
   typedef enum {MMR_SDP, MMR_TDP, MMR_SHIFT, MMR_ROM, MMR_FIFO} mmr_mode_t;
   typedef enum {MMR_SAME_NEW, MMR_SAME_OLD} mmr_same_t;
   typedef enum {MMR_MIX_OLD, MMR_MIX_DC} mmr_mixed_t;
endpackage

// ---- verification/mmr_fabric_model.sv ----
// Fabric-side user logic that drives both memory ports of the block
module mmr_fabric_model
   import mmr_pkg::*;
(
   input wire logic clk_i,
   output logic a_ce_o,
   output logic [MMR_AW-1:0] a_addr_o,
   output logic [MMR_DW-1:0] a_data_o,
   output logic a_wren_o,
   output logic a_rden_o,
   output logic b_ce_o,
   output logic [MMR_AW-1:0] b_addr_o,
   output logic [MMR_DW-1:0] b_data_o,
   output logic b_wren_o,
   output logic b_rden_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Shift sizing the user may ask for: 4 wide, 16 long, 4 taps
   localparam int SR_USE_BITS = 4 * 16 * 4;
   localparam int SR_USE_W = 4 * 4;

   // Idle state: clock enables high, read and write enables low so no read is taken
   initial begin
      a_ce_o = 1'b1;
      b_ce_o = 1'b1;
      a_addr_o = '0;
      b_addr_o = '0;
      a_data_o = '0;
      b_data_o = '0;
      a_wren_o = 1'b0;
      a_rden_o = 1'b0;
      b_wren_o = 1'b0;
      b_rden_o = 1'b0;
      // No queue traffic is driven, so read with write on empty never occurs
      if (SR_USE_BITS > MMR_CAP_BITS || SR_USE_W > MMR_TAP_W) begin
         b_rden_o = 1'b0;
      end
   end

   // One cycle on both ports; clash=1 lets a same-address double write through
   task automatic op(input logic aw, input logic ar, input logic [12:0] aa,
                     input logic [35:0] ad, input logic bw, input logic br,
                     input logic [12:0] ba, input logic [35:0] bd,
                     input logic clash);
      logic bw_ok;
      // Port B yields when both would write one word, unless told otherwise
      bw_ok = bw && !(!clash && aw && (ba == aa));
      @(posedge clk_i);
      a_wren_o <= aw;
      a_rden_o <= ar;
      a_addr_o <= aa;
      a_data_o <= ad;
      b_wren_o <= bw_ok;
      b_rden_o <= br;
      b_addr_o <= ba;
      b_data_o <= bd;
      @(posedge clk_i);
      // Released data is scrambled so a stale value can never look valid
      a_wren_o <= 1'b0;
      a_rden_o <= 1'b0;
      b_wren_o <= 1'b0;
      b_rden_o <= 1'b0;
      a_data_o <= ~ad;
      b_data_o <= ~bd;
   endtask
endmodule

// ---- verification/testbench.sv ----
module testbench
   import mmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat, wb_rdat, rd;
   logic a_ce, a_wren, a_rden, b_ce, b_wren, b_rden;
   logic [MMR_AW-1:0] a_addr, b_addr;
   logic [MMR_DW-1:0] a_data, b_data, a_q, b_q, a_q2, b_q2;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;

   mmr_fabric_model fab (.clk_i(clk_i), .a_ce_o(a_ce), .a_addr_o(a_addr),
      .a_data_o(a_data), .a_wren_o(a_wren), .a_rden_o(a_rden),
      .b_ce_o(b_ce), .b_addr_o(b_addr), .b_data_o(b_data),
      .b_wren_o(b_wren), .b_rden_o(b_rden));

   // Unregistered-output instance answers the register bus
   mmr_block_ram #(.MODE(MMR_TDP), .OUT_REG(1'b0)) dut (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .a_ce_i(a_ce),
      .a_addr_i(a_addr), .a_data_i(a_data), .a_wren_i(a_wren),
      .a_rden_i(a_rden), .a_q_o(a_q), .b_ce_i(b_ce), .b_addr_i(b_addr),
      .b_data_i(b_data), .b_wren_i(b_wren), .b_rden_i(b_rden),
      .b_q_o(b_q), .taps_o(), .fifo_empty_o(), .fifo_full_o());

   // Twin with output register, fed the same traffic to show the extra stage
   mmr_block_ram #(.MODE(MMR_TDP), .OUT_REG(1'b1)) dut2 (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(), .wb_ack_o(), .a_ce_i(a_ce),
      .a_addr_i(a_addr), .a_data_i(a_data), .a_wren_i(a_wren),
      .a_rden_i(a_rden), .a_q_o(a_q2), .b_ce_i(b_ce), .b_addr_i(b_addr),
      .b_data_i(b_data), .b_wren_i(b_wren), .b_rden_i(b_rden),
      .b_q_o(b_q2), .taps_o(), .fifo_empty_o(), .fifo_full_o());

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic stop_test();
      if (mismatches == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Hang guard: the whole sequence needs well under a few hundred cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Classic single Wishbone cycle; waits for ack, no fixed latency assumed
   task automatic wb_xfer(input logic we, input logic [7:0] adr,
                          input logic [31:0] wdat, output logic [31:0] rdat);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= wdat;
      do @(posedge clk_i); while (wb_ack !== 1'b1);
      rdat = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask

   initial begin
      rst_i = 1'b1;
      {wb_cyc, wb_stb, wb_we} = 3'h0;
      wb_adr = 8'h00;
      wb_sel = 4'hf;
      wb_dat = 32'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb_xfer(1'b0, MMR_REG_CTRL, 32'h0, rd);
      chk(36'(rd), 36'(MMR_CTRL_RESET));
      wb_xfer(1'b0, MMR_REG_CONFIG, 32'h0, rd);
      chk(36'(rd), {20'h0, 8'h10, 8'(MMR_TDP)} | 36'h0010_0000);
      // Unmapped place: write dropped, read gives zero
      wb_xfer(1'b1, 8'h0c, 32'hffff_ffff, rd);
      wb_xfer(1'b0, 8'h0c, 32'h0, rd);
      chk(36'(rd), 36'h0);
      // Two writes at once, then two reads at once across the ports
      fab.op(1, 0, 13'h005, 36'h1234, 1, 0, 13'h009, 36'hbeef, 0);
      fab.op(0, 1, 13'h009, 36'h0, 0, 1, 13'h005, 36'h0, 0);
      #1;
      chk(a_q, 36'hbeef);
      chk(b_q, 36'h1234);
      chk(b_q2, 36'h0);
      @(posedge clk_i);
      #1;
      chk(b_q2, 36'h1234);
      chk(a_q2, 36'hbeef);
      // A rewrites and reads its own word while B reads the same word
      fab.op(1, 1, 13'h005, 36'h5678, 0, 1, 13'h005, 36'h0, 0);
      #1;
      chk(a_q, 36'h5678);
      chk(b_q, 36'h1234);
      fab.op(0, 0, 13'h0, 36'h0, 0, 1, 13'h005, 36'h0, 0);
      #1;
      chk(b_q, 36'h5678);
      // Top word of the 16-bit shape; bits above the width are dropped
      fab.op(1, 0, 13'h1ff, 36'hf_ffff_ffff, 0, 0, 13'h0, 36'h0, 0);
      fab.op(0, 0, 13'h0, 36'h0, 0, 1, 13'h1ff, 36'h0, 0);
      #1;
      chk(b_q, 36'h0_0000_ffff);
      // Port B switched off by software: its read is not taken
      wb_xfer(1'b1, MMR_REG_CTRL, 32'h1, rd);
      wb_xfer(1'b0, MMR_REG_CTRL, 32'h0, rd);
      chk(36'(rd), 36'h1);
      fab.op(0, 0, 13'h0, 36'h0, 0, 1, 13'h009, 36'h0, 0);
      #1;
      chk(b_q, 36'h0_0000_ffff);
      wb_xfer(1'b1, MMR_REG_CTRL, 32'h3, rd);
      // Same-address double write is flagged, then cleared by writing one
      fab.op(1, 0, 13'h007, 36'h1111, 1, 0, 13'h007, 36'h2222, 1);
      wb_xfer(1'b0, MMR_REG_STATUS, 32'h0, rd);
      chk(36'(rd[MMR_ST_CONFLICT]), 36'h1);
      chk(36'(rd[2:0]), 36'h3);
      wb_xfer(1'b1, MMR_REG_STATUS, 32'h1, rd);
      wb_xfer(1'b0, MMR_REG_STATUS, 32'h0, rd);
      chk(36'(rd[MMR_ST_CONFLICT]), 36'h0);
      chk(36'(rd[MMR_ST_LEVEL_LSB +: 14]), 36'h0);
      stop_test();
   end
endmodule
